// File: tmrc_register_control.sv
// register bank and alarm logic of the temperature monitor
// Function
// - first write byte after the address loads the internal pointer
// - second write byte goes to pointed register; reads return it
// - pointer resets to zero so first read gives local result
// - result registers written only by converter, reset zero
// - configuration read at one address, written at another, resets zero
// - mask bit disables limit alarm, ignored in second overtemp mode
// - standby bit halts conversions, cleared converts continuously
// - in standby bus and alarm outputs keep working, update at once
// - pin select bit picks limit alarm or second overtemp output
// - range bit selects plain or extended measurement range
// - rate register split read/write, low bits pick power-of-two divider
// - each code up to ten doubles rate, 16 s down to 64 per second
// - each interval both channels are converted
// - rate register resets to sixteen conversions per second
// - limits and hysteresis host accessible; remote limits two bytes
// - above high counts as out of limit, at/below low too outside second overtemp mode
// - overtemp output low when a result exceeds its overtemp limit
// - second overtemp output low when a result exceeds high limit
// - one hysteresis value, default ten, shared by both channels
// - limits compared raw, never converted on range change
// - extended range bytes are offset binary by sixty-four
// - low result read freezes high byte until it is read
// - overtemp output releases only at limit minus hysteresis
`timescale 1ns/10ps
`default_nettype none
module tmrc_register_control #(
   parameter int FAST_INTERVAL = tmrc_pkg::FAST_INTERVAL_CYCLES
) (
   input  wire logic       clock,
   input  wire logic       reset,
   input  wire logic       linkClock,
   input  wire logic       linkReset,
   input  wire logic       linkWriteValid,
   input  wire logic       linkFirstByte,
   input  wire logic [7:0] linkWriteByte,
   input  wire logic       linkReadReq,
   output var  logic       linkBusy,
   output var  logic       linkReadValid,
   output var  logic [7:0] linkReadData,
   output var  logic       convStart,
   input  wire logic       convValid,
   input  wire logic [7:0] convLocal,
   input  wire logic [7:0] convRemoteHigh,
   input  wire logic [7:0] convRemoteLow,
   output var  logic       rangeExtended,
   output var  logic       overtempN,
   output var  logic       sharedPinN,
   output var  logic [3:0] outOfLimit
);
   // ==========================================================
   // declarations
   tmrc_pkg::tmrc_link_state_t linkState_ff;
   tmrc_pkg::tmrc_req_t        reqHold_ff;
   logic                       reqTgl_ff;
   logic                       ackS1_ff, ackS2_ff, ackS3_ff;
   logic                       linkBusy_ff, linkReadValid_ff;
   logic [7:0]                 linkReadData_ff;
   logic                       reqS1_ff, reqS2_ff, reqS3_ff;
   logic                       ackTgl_ff;
   logic [7:0]                 rdData_ff, readMux;
   logic [7:0]                 pointer_ff, config_ff, rate_ff;
   logic [7:0]                 locHigh_ff, locLow_ff;
   logic [7:0]                 remHighHi_ff, remHighLo_ff;
   logic [7:0]                 remLowHi_ff, remLowLo_ff;
   logic [7:0]                 locTherm_ff, remTherm_ff, hyst_ff;
   logic [7:0]                 localRes_ff, remHi_ff, remLo_ff;
   logic                       lock_ff, lockNow;
   logic [tmrc_pkg::TIMER_W-1:0] timer_ff;
   logic                       convStart_ff;
   logic                       thermLoc_ff, thermRem_ff;
   logic                       therm2Loc_ff, therm2Rem_ff;
   logic                       nxt_thermLoc, nxt_thermRem;
   logic                       nxt_therm2Loc, nxt_therm2Rem;
   logic                       overtempN_ff, sharedPinN_ff;
   logic [3:0]                 outOfLimit_ff, trips;
   logic                       reqEvent, rdEvent, ptrWrite, regWrite;
   logic                       ackEvent, standby, pinTherm2;

   // ==========================================================
   // functions
   function automatic logic [tmrc_pkg::TIMER_W-1:0] intervalFor(
      input logic [7:0] rate);
      logic [3:0] code;
      logic [3:0] shift;
      code = rate[3:0];
      if (code > tmrc_pkg::RATE_CODE_MAX) begin
         code = tmrc_pkg::RATE_CODE_MAX;
      end
      shift = 4'(tmrc_pkg::RATE_CODE_MAX - code);
      intervalFor = tmrc_pkg::TIMER_W'(FAST_INTERVAL) << shift;
   endfunction : intervalFor

   // saturating release point so a large hysteresis cannot wrap
   function automatic logic [7:0] releaseAt(
      input logic [7:0] lim,
      input logic [7:0] hy);
      releaseAt = (lim > hy) ? 8'(lim - hy) : 8'h00;
   endfunction : releaseAt

   function automatic logic thermNext(
      input logic       active,
      input logic [7:0] val,
      input logic [7:0] lim,
      input logic [7:0] hy);
      if (val > lim) begin
         thermNext = 1'b1;
      end else if (val <= releaseAt(lim, hy)) begin
         thermNext = 1'b0;
      end else begin
         thermNext = active;
      end
   endfunction : thermNext

   // ==========================================================
   // link side: capture a byte or read request, hold it until acked
   always_ff @(posedge linkClock) begin
      if (linkReset) begin
         linkState_ff <= tmrc_pkg::LINK_IDLE;
         reqHold_ff   <= '0;
         reqTgl_ff    <= 1'b0;
         linkBusy_ff  <= 1'b0;
      end else begin
         case (linkState_ff)
            tmrc_pkg::LINK_IDLE: begin
               if (linkReadReq || linkWriteValid) begin
                  reqHold_ff.isRead <= linkReadReq;
                  reqHold_ff.first  <= linkFirstByte;
                  reqHold_ff.data   <= linkWriteByte;
                  reqTgl_ff         <= ~reqTgl_ff;
                  linkBusy_ff       <= 1'b1;
                  linkState_ff      <= tmrc_pkg::LINK_WAIT;
               end
            end
            tmrc_pkg::LINK_WAIT: begin
               if (ackEvent) begin
                  linkBusy_ff  <= 1'b0;
                  linkState_ff <= tmrc_pkg::LINK_IDLE;
               end
            end
            default: begin
               linkState_ff <= tmrc_pkg::LINK_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge linkClock) begin
      if (linkReset) begin
         ackS1_ff <= 1'b0;
         ackS2_ff <= 1'b0;
         ackS3_ff <= 1'b0;
      end else begin
         ackS1_ff <= ackTgl_ff;
         ackS2_ff <= ackS1_ff;
         ackS3_ff <= ackS2_ff;
      end
   end

   assign ackEvent = ackS2_ff ^ ackS3_ff;

   // read data is held by the core until the next request, safe to take
   always_ff @(posedge linkClock) begin
      if (linkReset) begin
         linkReadValid_ff <= 1'b0;
         linkReadData_ff  <= 8'h00;
      end else begin
         linkReadValid_ff <= ackEvent && reqHold_ff.isRead;
         if (ackEvent && reqHold_ff.isRead) begin
            linkReadData_ff <= rdData_ff;
         end
      end
   end

   // ==========================================================
   // core side of the handshake
   always_ff @(posedge clock) begin
      if (reset) begin
         reqS1_ff <= 1'b0;
         reqS2_ff <= 1'b0;
         reqS3_ff <= 1'b0;
      end else begin
         reqS1_ff <= reqTgl_ff;
         reqS2_ff <= reqS1_ff;
         reqS3_ff <= reqS2_ff;
      end
   end

   assign reqEvent  = reqS2_ff ^ reqS3_ff;
   assign rdEvent   = reqEvent && reqHold_ff.isRead;
   assign ptrWrite  = reqEvent && !reqHold_ff.isRead && reqHold_ff.first;
   assign regWrite  = reqEvent && !reqHold_ff.isRead && !reqHold_ff.first;
   assign standby   = config_ff[tmrc_pkg::CFG_STANDBY_BIT];
   assign pinTherm2 = config_ff[tmrc_pkg::CFG_PIN_BIT];

   // ==========================================================
   // pointer
   always_ff @(posedge clock) begin
      if (reset) begin
         pointer_ff <= tmrc_pkg::POINTER_RST;
      end else if (ptrWrite) begin
         pointer_ff <= reqHold_ff.data;
      end
   end

   // ==========================================================
   // writable registers; result and unused addresses fall through
   always_ff @(posedge clock) begin
      if (reset) begin
         config_ff    <= tmrc_pkg::CONFIG_RST;
         rate_ff      <= tmrc_pkg::RATE_RST;
         locHigh_ff   <= tmrc_pkg::HIGH_LIMIT_RST;
         locLow_ff    <= tmrc_pkg::LOW_LIMIT_RST;
         remHighHi_ff <= tmrc_pkg::HIGH_LIMIT_RST;
         remHighLo_ff <= 8'h00;
         remLowHi_ff  <= tmrc_pkg::LOW_LIMIT_RST;
         remLowLo_ff  <= 8'h00;
         locTherm_ff  <= tmrc_pkg::OVERTEMP_OUTPUT_LIMIT_RST;
         remTherm_ff  <= tmrc_pkg::OVERTEMP_OUTPUT_LIMIT_RST;
         hyst_ff      <= tmrc_pkg::HYST_RST;
      end else if (regWrite) begin
         case (pointer_ff)
            // reserved bits dropped in case the host breaks the convention
            tmrc_pkg::WR_CONFIG:
               config_ff <= reqHold_ff.data & tmrc_pkg::CFG_USED_MASK;
            tmrc_pkg::WR_RATE:
               rate_ff <= {4'h0, reqHold_ff.data[3:0]};
            tmrc_pkg::WR_LOC_HIGH:      locHigh_ff   <= reqHold_ff.data;
            tmrc_pkg::WR_LOC_LOW:       locLow_ff    <= reqHold_ff.data;
            tmrc_pkg::WR_REM_HIGH_HI:   remHighHi_ff <= reqHold_ff.data;
            tmrc_pkg::ADDR_REM_HIGH_LO: remHighLo_ff <= reqHold_ff.data;
            tmrc_pkg::WR_REM_LOW_HI:    remLowHi_ff  <= reqHold_ff.data;
            tmrc_pkg::ADDR_REM_LOW_LO:  remLowLo_ff  <= reqHold_ff.data;
            tmrc_pkg::ADDR_LOC_OVERTEMP_OUTPUT:   locTherm_ff  <= reqHold_ff.data;
            tmrc_pkg::ADDR_REM_OVERTEMP_OUTPUT:   remTherm_ff  <= reqHold_ff.data;
            tmrc_pkg::ADDR_HYST:        hyst_ff      <= reqHold_ff.data;
            default: ;
         endcase
      end
   end

   // ==========================================================
   // read mux
   always_comb begin
      case (pointer_ff)
         tmrc_pkg::ADDR_LOCAL:       readMux = localRes_ff;
         tmrc_pkg::ADDR_REM_HI:      readMux = remHi_ff;
         tmrc_pkg::ADDR_REM_LO:      readMux = remLo_ff;
         tmrc_pkg::RD_CONFIG:        readMux = config_ff;
         tmrc_pkg::RD_RATE:          readMux = rate_ff;
         tmrc_pkg::RD_LOC_HIGH:      readMux = locHigh_ff;
         tmrc_pkg::RD_LOC_LOW:       readMux = locLow_ff;
         tmrc_pkg::RD_REM_HIGH_HI:   readMux = remHighHi_ff;
         tmrc_pkg::RD_REM_LOW_HI:    readMux = remLowHi_ff;
         tmrc_pkg::ADDR_REM_HIGH_LO: readMux = remHighLo_ff;
         tmrc_pkg::ADDR_REM_LOW_LO:  readMux = remLowLo_ff;
         tmrc_pkg::ADDR_LOC_OVERTEMP_OUTPUT:   readMux = locTherm_ff;
         tmrc_pkg::ADDR_REM_OVERTEMP_OUTPUT:   readMux = remTherm_ff;
         tmrc_pkg::ADDR_HYST:        readMux = hyst_ff;
         default:                    readMux = tmrc_pkg::READ_UNMAPPED;
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         rdData_ff <= 8'h00;
         ackTgl_ff <= 1'b0;
      end else if (reqEvent) begin
         if (reqHold_ff.isRead) begin
            rdData_ff <= readMux;
         end
         ackTgl_ff <= ~ackTgl_ff;
      end
   end

   // ==========================================================
   // results and the high-byte freeze
   // a low-byte read in the same cycle as an update already freezes
   assign lockNow = lock_ff ||
                    (rdEvent && pointer_ff == tmrc_pkg::ADDR_REM_LO);

   always_ff @(posedge clock) begin
      if (reset) begin
         lock_ff <= 1'b0;
      end else if (rdEvent && pointer_ff == tmrc_pkg::ADDR_REM_LO) begin
         lock_ff <= 1'b1;
      end else if (rdEvent && pointer_ff == tmrc_pkg::ADDR_REM_HI) begin
         lock_ff <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         localRes_ff <= tmrc_pkg::RESULT_RST;
         remHi_ff    <= tmrc_pkg::RESULT_RST;
         remLo_ff    <= tmrc_pkg::RESULT_RST;
      end else if (convValid) begin
         localRes_ff <= convLocal;
         remLo_ff    <= convRemoteLow;
         if (!lockNow) begin
            remHi_ff <= convRemoteHigh;
         end
      end
   end

   // ==========================================================
   // conversion timer
   always_ff @(posedge clock) begin
      if (reset || standby) begin
         timer_ff     <= '0;
         convStart_ff <= 1'b0;
      end else if (timer_ff >= intervalFor(rate_ff) - 1'b1) begin
         timer_ff     <= '0;
         convStart_ff <= 1'b1;
      end else begin
         timer_ff     <= timer_ff + 1'b1;
         convStart_ff <= 1'b0;
      end
   end

   // ==========================================================
   // limit comparisons on raw bytes, whatever the range
   always_comb begin
      trips[3] = localRes_ff > locHigh_ff;
      trips[2] = localRes_ff <= locLow_ff;
      trips[1] = {remHi_ff, remLo_ff[7:6]} >
                 {remHighHi_ff, remHighLo_ff[7:6]};
      trips[0] = {remHi_ff, remLo_ff[7:6]} <=
                 {remLowHi_ff, remLowLo_ff[7:6]};
   end

   // outputs follow registers every cycle, standby or not
   always_comb begin
      nxt_thermLoc  = thermNext(thermLoc_ff, localRes_ff,
                                locTherm_ff, hyst_ff);
      nxt_thermRem  = thermNext(thermRem_ff, remHi_ff,
                                remTherm_ff, hyst_ff);
      nxt_therm2Loc = thermNext(therm2Loc_ff, localRes_ff,
                                locHigh_ff, hyst_ff);
      nxt_therm2Rem = thermNext(therm2Rem_ff, remHi_ff,
                                remHighHi_ff, hyst_ff);
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         thermLoc_ff   <= 1'b0;
         thermRem_ff   <= 1'b0;
         therm2Loc_ff  <= 1'b0;
         therm2Rem_ff  <= 1'b0;
         overtempN_ff  <= 1'b1;
         sharedPinN_ff <= 1'b1;
         outOfLimit_ff <= 4'h0;
      end else begin
         thermLoc_ff   <= nxt_thermLoc;
         thermRem_ff   <= nxt_thermRem;
         therm2Loc_ff  <= nxt_therm2Loc;
         therm2Rem_ff  <= nxt_therm2Rem;
         overtempN_ff  <= ~(nxt_thermLoc | nxt_thermRem);
         if (pinTherm2) begin
            sharedPinN_ff <= ~(nxt_therm2Loc | nxt_therm2Rem);
            outOfLimit_ff <= {trips[3], 1'b0, trips[1], 1'b0};
         end else begin
            sharedPinN_ff <= ~((|trips) &
                             ~config_ff[tmrc_pkg::CFG_MASK_BIT]);
            outOfLimit_ff <= trips;
         end
      end
   end

   // ==========================================================
   // outputs
   assign linkBusy      = linkBusy_ff;
   assign linkReadValid = linkReadValid_ff;
   assign linkReadData  = linkReadData_ff;
   assign convStart     = convStart_ff;
   assign rangeExtended = config_ff[tmrc_pkg::CFG_RANGE_BIT];
   assign overtempN     = overtempN_ff;
   assign sharedPinN    = sharedPinN_ff;
   assign outOfLimit    = outOfLimit_ff;

   // ==========================================================
   // assertions
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   property p_ptrLoad;
      ptrWrite |=> pointer_ff == $past(reqHold_ff.data);
   endproperty
   a_ptrLoad: assert property (p_ptrLoad)
      else $error("pointer not loaded by first byte");

   property p_readBack;
      rdEvent |=> rdData_ff == $past(readMux);
   endproperty
   a_readBack: assert property (p_readBack)
      else $error("read data not from pointed register");

   property p_ptrReset;
      $past(reset) |-> pointer_ff == 8'h00 && rate_ff == 8'h08;
   endproperty
   a_ptrReset: assert property (p_ptrReset)
      else $error("pointer or rate not at reset value");

   property p_resultRo;
      regWrite && pointer_ff == tmrc_pkg::ADDR_LOCAL && !convValid
         |=> $stable(localRes_ff);
   endproperty
   a_resultRo: assert property (p_resultRo)
      else $error("host write changed local result");

   property p_cfgWrite;
      regWrite && pointer_ff == tmrc_pkg::WR_CONFIG
         |=> config_ff == ($past(reqHold_ff.data) & 8'he4);
   endproperty
   a_cfgWrite: assert property (p_cfgWrite)
      else $error("configuration write not taken");

   property p_standby;
      standby && $past(standby) |-> !convStart_ff;
   endproperty
   a_standby: assert property (p_standby)
      else $error("conversion started in standby");

   property p_mask;
      !pinTherm2 && config_ff[7] |=> sharedPinN_ff;
   endproperty
   a_mask: assert property (p_mask)
      else $error("masked alarm driven low");

   property p_overtemp;
      localRes_ff > locTherm_ff |=> !overtempN_ff && thermLoc_ff;
   endproperty
   a_overtemp: assert property (p_overtemp)
      else $error("overtemp output not asserted");

   property p_hold;
      thermLoc_ff && localRes_ff > releaseAt(locTherm_ff, hyst_ff)
         |=> thermLoc_ff;
   endproperty
   a_hold: assert property (p_hold)
      else $error("overtemp released above hysteresis point");

   property p_freeze;
      lock_ff && convValid && !(rdEvent &&
         pointer_ff == tmrc_pkg::ADDR_REM_HI) |=> $stable(remHi_ff);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("remote high byte changed while frozen");

   property p_second_overtemp_output;
      pinTherm2 && localRes_ff > locHigh_ff |=> !sharedPinN_ff;
   endproperty
   a_second_overtemp_output: assert property (p_second_overtemp_output)
      else $error("second overtemp output not asserted");

   c_read:     cover property (rdEvent ##[1:20] rdData_ff != 8'h00);
   c_convert:  cover property (convStart_ff ##[1:50] convValid);
   c_overtemp: cover property (!overtempN_ff ##[1:100] overtempN_ff);
   c_freeze:   cover property (lock_ff ##[1:100] !lock_ff);
endmodule : tmrc_register_control
`default_nettype wire

// File: tmrc_pkg.sv
// constants and types of the temperature monitor register control
package tmrc_pkg;
   // ==========================================================
   // register addresses (read / write)
   localparam logic [7:0] ADDR_LOCAL       = 8'h00;
   localparam logic [7:0] ADDR_REM_HI      = 8'h01;
   localparam logic [7:0] RD_CONFIG        = 8'h03;
   localparam logic [7:0] RD_RATE          = 8'h04;
   localparam logic [7:0] RD_LOC_HIGH      = 8'h05;
   localparam logic [7:0] RD_LOC_LOW       = 8'h06;
   localparam logic [7:0] RD_REM_HIGH_HI   = 8'h07;
   localparam logic [7:0] RD_REM_LOW_HI    = 8'h08;
   localparam logic [7:0] WR_CONFIG        = 8'h09;
   localparam logic [7:0] WR_RATE          = 8'h0a;
   localparam logic [7:0] WR_LOC_HIGH      = 8'h0b;
   localparam logic [7:0] WR_LOC_LOW       = 8'h0c;
   localparam logic [7:0] WR_REM_HIGH_HI   = 8'h0d;
   localparam logic [7:0] WR_REM_LOW_HI    = 8'h0e;
   localparam logic [7:0] ADDR_REM_LO      = 8'h10;
   localparam logic [7:0] ADDR_REM_HIGH_LO = 8'h13;
   localparam logic [7:0] ADDR_REM_LOW_LO  = 8'h14;
   localparam logic [7:0] ADDR_REM_OVERTEMP_OUTPUT   = 8'h19;
   localparam logic [7:0] ADDR_LOC_OVERTEMP_OUTPUT   = 8'h20;
   localparam logic [7:0] ADDR_HYST        = 8'h21;
   // ==========================================================
   // reset values
   localparam logic [7:0] POINTER_RST      = 8'h00;
   localparam logic [7:0] RESULT_RST       = 8'h00;
   localparam logic [7:0] CONFIG_RST       = 8'h00;
   localparam logic [7:0] RATE_RST         = 8'h08;
   localparam logic [7:0] HIGH_LIMIT_RST   = 8'h55;
   localparam logic [7:0] LOW_LIMIT_RST    = 8'h00;
   localparam logic [7:0] OVERTEMP_OUTPUT_LIMIT_RST  = 8'h55;
   localparam logic [7:0] HYST_RST         = 8'h0a;
   localparam logic [7:0] READ_UNMAPPED    = 8'h00;
   // ==========================================================
   // configuration fields
   localparam int         CFG_MASK_BIT     = 7;
   localparam int         CFG_STANDBY_BIT  = 6;
   localparam int         CFG_PIN_BIT      = 5;
   localparam int         CFG_RANGE_BIT    = 2;
   localparam logic [7:0] CFG_USED_MASK    = 8'he4;
   localparam logic [3:0] RATE_CODE_MAX    = 4'ha;
   // ==========================================================
   // conversion timing
   localparam int SLOWEST_PERIOD_MS = 16000;
   localparam int CLK_HZ            = 10_000_000;
   localparam int RATE_STEPS        = 10;
   localparam int FAST_INTERVAL_CYCLES =
      SLOWEST_PERIOD_MS * (CLK_HZ / 1000) / (1 << RATE_STEPS);
   localparam int TIMER_W           = 28;
   // ==========================================================
   // types
   typedef struct packed {
      logic       isRead;
      logic       first;
      logic [7:0] data;
   } tmrc_req_t;

   typedef enum logic {LINK_IDLE, LINK_WAIT} tmrc_link_state_t;
endpackage : tmrc_pkg

// File: tmrc_host_model.sv
// host-side link model: pointer writes, data writes, reads
`timescale 1ns/10ps
`default_nettype none
module tmrc_host_model (
   input  wire logic       linkClock,
   input  wire logic       linkBusy,
   output var  logic       linkWriteValid,
   output var  logic       linkFirstByte,
   output var  logic [7:0] linkWriteByte,
   output var  logic       linkReadReq
);
   // ==========
   // transfer
   initial begin
      linkWriteValid = 1'b0;
      linkFirstByte  = 1'b0;
      linkWriteByte  = 8'h00;
      linkReadReq    = 1'b0;
   end
   task automatic send(input logic r, input logic f, input logic [7:0] b);
      int n;
      @(negedge linkClock);
      linkReadReq    = r;
      linkWriteValid = ~r;
      linkFirstByte  = f;
      linkWriteByte  = b;
      @(negedge linkClock);
      linkReadReq    = 1'b0;
      linkWriteValid = 1'b0;
      linkWriteByte  = ~b; // stale byte never left standing
      @(negedge linkClock);
      for (n = 0; n < 200 && linkBusy !== 1'b0; n++) @(negedge linkClock);
   endtask : send
endmodule : tmrc_host_model
`default_nettype wire

// File: temp_monitor_register_control_tb.sv
// self-checking bench of the temperature monitor register control
`timescale 1ns/10ps
`default_nettype none
module temp_monitor_register_control_tb;
   logic       clock = 1'b0, linkClock = 1'b0, reset = 1'b1;
   logic       linkReset = 1'b1, convValid = 1'b0;
   logic [7:0] convLocal = 8'h00, v, linkWriteByte, linkReadData;
   logic       linkWriteValid, linkFirstByte, linkReadReq, linkBusy;
   logic       linkReadValid, rangeExtended, overtempN, sharedPinN, convStart;
   logic [7:0] rh = 8'h30;
   int         s0, starts = 0;
   logic [3:0] outOfLimit;
   logic [7:0] expQ[$];
   int         mismatches = 0, num_checks = 0, seed = 47593;
   always #50 clock = ~clock;
   always #3 linkClock = ~linkClock;
   tmrc_register_control #(.FAST_INTERVAL(4)) dut_u (.clock(clock),
      .reset(reset), .linkClock(linkClock), .linkReset(linkReset),
      .linkWriteValid(linkWriteValid), .linkFirstByte(linkFirstByte),
      .linkWriteByte(linkWriteByte), .linkReadReq(linkReadReq),
      .linkBusy(linkBusy), .linkReadValid(linkReadValid),
      .linkReadData(linkReadData), .convStart(convStart),
      .convValid(convValid), .convLocal(convLocal),
      .convRemoteHigh(rh), .convRemoteLow(8'h00),
      .rangeExtended(rangeExtended), .overtempN(overtempN),
      .sharedPinN(sharedPinN), .outOfLimit(outOfLimit));
   tmrc_host_model host_u (.linkClock(linkClock), .linkBusy(linkBusy),
      .linkWriteValid(linkWriteValid), .linkFirstByte(linkFirstByte),
      .linkWriteByte(linkWriteByte), .linkReadReq(linkReadReq));
   // ==========
   // tasks
   task automatic check(string s, logic [7:0] e, logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", s, e, g);
      end
   endtask : check
   task automatic rd(logic [7:0] a, logic [7:0] e);
      host_u.send(1'b0, 1'b1, a);
      expQ.push_back(e);
      host_u.send(1'b1, 1'b0, 8'h00);
   endtask : rd
   task automatic wr(logic [7:0] a, logic [7:0] d);
      host_u.send(1'b0, 1'b1, a);
      host_u.send(1'b0, 1'b0, d);
   endtask : wr
   task automatic conv(logic [7:0] l, logic [7:0] h);
      @(negedge clock);
      convLocal = l;
      rh        = h;
      convValid = 1'b1;
      @(negedge clock);
      convValid = 1'b0;
      repeat (2) @(negedge clock);
   endtask : conv
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test
   // ==========
   // read watcher and sequence
   always @(posedge linkClock) begin
      if (linkReadValid === 1'b1)
         check("readData", expQ.pop_front(), linkReadData);
   end
   always @(posedge clock) begin
      if (convStart === 1'b1) starts++;
   end
   initial begin
      #200000;
      mismatches++;
      end_of_test;
   end
   initial begin
      repeat (2) @(negedge clock);
      reset = 1'b0;
      linkReset = 1'b0;
      expQ.push_back(8'h00);
      host_u.send(1'b1, 1'b0, 8'h00);
      rd(8'h03, 8'h00);
      rd(8'h04, 8'h08);
      rd(8'h21, 8'h0a);
      // code 8 runs four times slower than the fastest interval
      @(negedge clock);
      s0 = starts;
      repeat (32) @(negedge clock);
      check("convStart", 8'h02, 8'(starts - s0));
      v = 8'($random(seed));
      wr(8'h00, v);
      rd(8'h00, 8'h00);
      v = 8'({$random(seed)} % 11);
      wr(8'h0a, v);
      rd(8'h04, v);
      wr(8'h09, 8'h44);
      rd(8'h03, 8'h44);
      @(negedge clock);
      s0 = starts;
      repeat (32) @(negedge clock);
      check("convStart", 8'h00, 8'(starts - s0));
      check("rangeExtended", 8'h01, {7'h0, rangeExtended});
      conv(8'h60, 8'h30);
      check("overtempN", 8'h00, {7'h0, overtempN});
      check("outOfLimit", 8'h08, {4'h0, outOfLimit});
      check("sharedPinN", 8'h00, {7'h0, sharedPinN});
      rd(8'h10, 8'h00);
      conv(8'h4c, 8'h31);
      check("overtempN", 8'h00, {7'h0, overtempN});
      conv(8'h4b, 8'h31);
      check("overtempN", 8'h01, {7'h0, overtempN});
      rd(8'h01, 8'h30);
      rd(8'h00, 8'h4b);
      wr(8'h09, 8'ha0);
      conv(8'h60, 8'h31);
      check("sharedPinN", 8'h00, {7'h0, sharedPinN});
      rd(8'h01, 8'h31);
      wr(8'h0b, v);
      rd(8'h05, v);
      wr(8'h09, 8'h80);
      repeat (2) @(negedge clock);
      check("sharedPinN", 8'h01, {7'h0, sharedPinN});
      check("outOfLimit", 8'h08, {4'h0, outOfLimit});
      repeat (20) @(posedge clock);
      // a stuck link leaves reads unanswered
      check("pendingReads", 8'h00, 8'(expQ.size()));
      end_of_test;
   end
endmodule : temp_monitor_register_control_tb
`default_nettype wire
